// [rtl/dee_ctrl.sv]
/*
 data nonvolatile store access controller: control, address and data
 registers behind an APB slave, sequencing reads and timed write cycles.
 assumes software holds power on and leaves registers alone during a write.
*/
`timescale 1ns/1ps
module dee_ctrl
   import dee_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic nvm_power_on
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   dee_state_t state_r, state_nxt;
   logic readReq_r, readReq_nxt;
   logic writeReq_r, writeReq_nxt;
   logic nvmWriteEnable_r, nvmWriteEnable_nxt;
   logic nvmPowerOn_r, nvmPowerOn_nxt;
   logic [6:0] location_r, location_nxt;
   logic [7:0] dataByte_r, dataByte_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic [7:0] writeLen_r, writeLen_nxt;
   logic nvm_write_busy;
   logic wrAcc, rdAcc, hitCtl, hitAdr, hitDat;
   logic [7:0] ctlView;
   dee_array_if arr ();

   dee_array u_array (
      .sys_clk(sys_clk),
      .port(arr.mem)
   );

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign wrAcc = psel && penable && pwrite && pstrb[0];
   assign rdAcc = psel && penable && !pwrite;
   assign hitCtl = paddr == DEE_OFS_CONTROL;
   assign hitAdr = paddr == DEE_OFS_ADDRESS;
   assign hitDat = paddr == DEE_OFS_DATA;
   // read data registered one cycle ahead: answer in the setup-to-access step
   assign pready = psel && penable;
   assign pslverr = psel && penable && !(hitCtl || hitAdr || hitDat);
   assign nvm_write_busy = state_r == DEE_WRITE;
   assign ctlView = {readReq_r, writeReq_r, nvmWriteEnable_r, nvm_write_busy, nvmPowerOn_r, 3'h0};

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      readReq_nxt = readReq_r;
      writeReq_nxt = writeReq_r;
      nvmWriteEnable_nxt = nvmWriteEnable_r;
      nvmPowerOn_nxt = nvmPowerOn_r;
      location_nxt = location_r;
      dataByte_nxt = dataByte_r;
      cnt_nxt = cnt_r;
      prdata_nxt = prdata_r;
      if (wrAcc && hitCtl) begin
         nvmWriteEnable_nxt = pwdata[DEE_BIT_WREN];
         nvmPowerOn_nxt = pwdata[DEE_BIT_PWR];
      end
      if (wrAcc && hitAdr) begin
         location_nxt = pwdata[6:0];
      end
      if (wrAcc && hitDat) begin
         dataByte_nxt = pwdata[7:0];
      end
      case (state_r)
         DEE_IDLE: begin
            // write wins if both asked together; read waits its turn
            if (writeReq_r && nvmWriteEnable_r && nvmPowerOn_r) begin
               state_nxt = DEE_WRITE;
               cnt_nxt = DEE_WRITE_CNT;
            end else if (writeReq_r && !nvmWriteEnable_r) begin
               writeReq_nxt = 1'b0;
            end else if (readReq_r && nvmPowerOn_r) begin
               state_nxt = DEE_READ;
            end
         end
         DEE_READ: begin
            dataByte_nxt = arr.rdByte;
            readReq_nxt = 1'b0;
            state_nxt = DEE_IDLE;
         end
         DEE_WRITE: begin
            cnt_nxt = cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
               writeReq_nxt = 1'b0;
               state_nxt = DEE_IDLE;
            end
         end
         default: state_nxt = DEE_IDLE;
      endcase
      // software sets requests only; a set in the clearing cycle wins
      if (wrAcc && hitCtl && pwdata[DEE_BIT_READ]) begin
         readReq_nxt = 1'b1;
      end
      if (wrAcc && hitCtl && pwdata[DEE_BIT_WRITE] && pwdata[DEE_BIT_WREN]) begin
         writeReq_nxt = 1'b1;
      end
      if (psel && !penable && !pwrite) begin
         prdata_nxt = 32'h0;
         if (paddr == DEE_OFS_CONTROL) begin
            prdata_nxt = {24'h0, ctlView};
         end else if (paddr == DEE_OFS_ADDRESS) begin
            prdata_nxt = {25'h0, location_r};
         end else if (paddr == DEE_OFS_DATA) begin
            prdata_nxt = {24'h0, dataByte_r};
         end
      end
   end

   // ----------------------------------------
   // array strobes
   // ----------------------------------------
   assign arr.powerOn = nvmPowerOn_r;
   assign arr.readEn = state_r == DEE_IDLE && !writeReq_r && readReq_r && nvmPowerOn_r;
   assign arr.writeEn = state_r == DEE_WRITE && cnt_r == 8'h01;
   assign arr.location = location_r;
   assign arr.wrByte = dataByte_r;
   assign nvm_power_on = nvmPowerOn_r;
   assign prdata = prdata_r;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r <= DEE_IDLE;
         readReq_r <= DEE_RST_CONTROL[DEE_BIT_READ];
         writeReq_r <= DEE_RST_CONTROL[DEE_BIT_WRITE];
         nvmWriteEnable_r <= DEE_RST_CONTROL[DEE_BIT_WREN];
         nvmPowerOn_r <= DEE_RST_CONTROL[DEE_BIT_PWR];
         location_r <= DEE_RST_ADDRESS;
         dataByte_r <= DEE_RST_DATA;
         cnt_r <= 8'h00;
         prdata_r <= 32'h0;
      end else begin
         state_r <= state_nxt;
         readReq_r <= readReq_nxt;
         writeReq_r <= writeReq_nxt;
         nvmWriteEnable_r <= nvmWriteEnable_nxt;
         nvmPowerOn_r <= nvmPowerOn_nxt;
         location_r <= location_nxt;
         dataByte_r <= dataByte_nxt;
         cnt_r <= cnt_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // ----------------------------------------
   // write length helper
   // ----------------------------------------
   // counts cycles spent in the write state; feeds the length check only
   always_comb begin
      writeLen_nxt = 8'h00;
      if (state_r == DEE_WRITE) begin
         writeLen_nxt = writeLen_r + 8'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         writeLen_r <= 8'h00;
      end else begin
         writeLen_r <= writeLen_nxt;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_read_clears: assert property (@(posedge sys_clk) disable iff (rst)
      state_r == DEE_READ && !(wrAcc && hitCtl && pwdata[DEE_BIT_READ]) |=> !readReq_r && state_r == DEE_IDLE)
      else $error("read request not cleared after read");
   chk_write_holds: assert property (@(posedge sys_clk) disable iff (rst)
      state_r == DEE_WRITE |-> writeReq_r)
      else $error("write request dropped during write cycle");
   chk_write_len: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(state_r == DEE_WRITE) |-> writeLen_r == DEE_WRITE_CNT)
      else $error("write cycle length wrong");
   chk_wren_gate: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(state_r == DEE_WRITE) |-> $past(nvmWriteEnable_r))
      else $error("write started without write enable");
   chk_busy_flag: assert property (@(posedge sys_clk) disable iff (rst)
      psel && !penable && !pwrite && hitCtl |=> prdata_r[DEE_BIT_BUSY] == $past(state_r == DEE_WRITE))
      else $error("busy flag mismatch");
   chk_power_gate: assert property (@(posedge sys_clk) disable iff (rst)
      (arr.readEn || arr.writeEn) |-> nvmPowerOn_r)
      else $error("array access while powered down");
   chk_low_zero: assert property (@(posedge sys_clk) disable iff (rst)
      psel && !penable && !pwrite && paddr == DEE_OFS_CONTROL |=> prdata_r[2:0] == 3'h0)
      else $error("unused control bits not zero");
   chk_read_data: assert property (@(posedge sys_clk) disable iff (rst)
      arr.readEn |=> ##1 dataByte_r == $past(arr.rdByte))
      else $error("read byte not placed in data register");
   chk_addr_top: assert property (@(posedge sys_clk) disable iff (rst)
      psel && !penable && !pwrite && paddr == DEE_OFS_ADDRESS |=> prdata_r[31:7] == 25'h0)
      else $error("address top bit not zero");
   cov_read: cover property (@(posedge sys_clk) disable iff (rst) state_r == DEE_READ);
   cov_write: cover property (@(posedge sys_clk) disable iff (rst) $fell(state_r == DEE_WRITE));
   cov_blocked: cover property (@(posedge sys_clk) disable iff (rst) $fell(writeReq_r) && state_r == DEE_IDLE);
   cov_err: cover property (@(posedge sys_clk) disable iff (rst) pslverr);
endmodule

// [rtl/dee_pkg.sv]
/*
 package for the data nonvolatile store access controller: register offsets,
 field positions, reset values, timing counts, state type.
 assumes an APB slave with 32-bit data, one register per aligned word.
*/
package dee_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [11:0] DEE_OFS_CONTROL = 12'h000;
   localparam logic [11:0] DEE_OFS_ADDRESS = 12'h004;
   localparam logic [11:0] DEE_OFS_DATA = 12'h008;
   // ----------------------------------------
   // control field positions, array widths and depth
   // ----------------------------------------
   localparam int DEE_BIT_READ = 7;
   localparam int DEE_BIT_WRITE = 6;
   localparam int DEE_BIT_WREN = 5;
   localparam int DEE_BIT_BUSY = 4;
   localparam int DEE_BIT_PWR = 3;
   localparam int DEE_ADDR_W = 7;
   localparam int DEE_DATA_W = 8;
   localparam int DEE_DEPTH = 128;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] DEE_RST_CONTROL = 8'h00;
   localparam logic [6:0] DEE_RST_ADDRESS = 7'h00;
   localparam logic [7:0] DEE_RST_DATA = 8'h00;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int DEE_CLK_MHZ = 200;
   localparam int DEE_WRITE_TIME_NS = 100;
   localparam int DEE_WRITE_CYCLES = (DEE_WRITE_TIME_NS * DEE_CLK_MHZ + 999) / 1000;
   localparam logic [7:0] DEE_WRITE_CNT = 8'(DEE_WRITE_CYCLES);
   typedef enum logic [1:0] {
      DEE_IDLE = 2'b00,
      DEE_READ = 2'b01,
      DEE_WRITE = 2'b10
   } dee_state_t;
endpackage

// [rtl/dee_array_if.sv]
/*
 interface between the controller and its storage array.
 assumes both ends sit on sys_clk.
*/
`timescale 1ns/1ps
interface dee_array_if;
   logic powerOn;
   logic readEn;
   logic writeEn;
   logic [6:0] location;
   logic [7:0] wrByte;
   logic [7:0] rdByte;
   modport ctrl (output powerOn, output readEn, output writeEn, output location, output wrByte, input rdByte);
   modport mem (input powerOn, input readEn, input writeEn, input location, input wrByte, output rdByte);
endinterface

// [rtl/dee_array.sv]
/*
 128 x 8 storage array with registered read data.
 assumes requests only while powered; content survives power-down.
*/
`timescale 1ns/1ps
module dee_array
   import dee_pkg::*;
(
   input wire logic sys_clk,
   dee_array_if.mem port
);
   logic [7:0] store [DEE_DEPTH];
   logic [7:0] rdByte_r;
   // no reset on content: it stands for nonvolatile cells
   always_ff @(posedge sys_clk) begin
      if (port.powerOn && port.writeEn) begin
         store[port.location] <= port.wrByte;
      end
      if (port.powerOn && port.readEn) begin
         rdByte_r <= store[port.location];
      end
   end
   assign port.rdByte = rdByte_r;
endmodule

// [sim/dee_apb_host.sv]
/*
 partner model: the software side of the register bus, an APB master with a
 single transfer task. assumes a slave that raises pready within 50 cycles.
*/
`timescale 1ns/1ps
module dee_apb_host (
   input wire logic sys_clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic timedOut = 1'b0;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'hf;
   end
   // ----------------------------------------
   // one transfer
   // ----------------------------------------
   // callers leave the block alone while busy is set
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) timedOut = 1'b1;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// [sim/data_eeprom_access_control_bench.sv]
/*
 self-checking bench for dee_ctrl: register access, timed writes, reads.
 assumes dee_ctrl holds its own storage array behind the registers.
*/
`timescale 1ns/1ps
module data_eeprom_access_control_bench;
   import dee_pkg::*;
   logic sys_clk;
   logic rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, nvmPowerOn;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [3:0] pstrb;
   logic errv;
   int failures = 0;
   int checks = 0;
   logic [6:0] locs [2] = '{7'h7f, 7'h00};
   logic [7:0] vals [2] = '{8'h5a, 8'hc3};
   dee_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .nvm_power_on(nvmPowerOn));
   dee_apb_host u_host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic results();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic xf(input logic wr, input logic [11:0] a, input logic [31:0] d);
      u_host.xfer(wr, a, d, rdv, errv);
      if (u_host.timedOut) begin
         failures++;
         results();
      end
   endtask
   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
      xf(1'b0, a, 32'h0000_0000);
      chk(nm, rdv, exp);
   endtask
   // request-bit polling bounded to 40 reads; a stuck request ends the run
   task automatic poll(input int b);
      for (int n = 0; n < 40; n++) begin
         xf(1'b0, DEE_OFS_CONTROL, 32'h0000_0000);
         if (rdv[b] === 1'b0) return;
      end
      chk("request clears", rdv, rdv & ~(32'h1 << b));
      results();
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      rdc("control reset", DEE_OFS_CONTROL, 32'h00);
      rdc("address reset", DEE_OFS_ADDRESS, 32'h00);
      rdc("data reset", DEE_OFS_DATA, 32'h00);
      chk("power reset", {31'h0, nvmPowerOn}, 32'h0);
      $display("test reset done");
      xf(1'b1, DEE_OFS_ADDRESS, 32'hffff_ffff);
      rdc("address width", DEE_OFS_ADDRESS, 32'h7f);
      xf(1'b1, DEE_OFS_DATA, 32'h1234_56a5);
      rdc("data width", DEE_OFS_DATA, 32'ha5);
      xf(1'b1, DEE_OFS_CONTROL, 32'h07);
      rdc("control unused", DEE_OFS_CONTROL, 32'h00);
      rdc("unmapped", 12'h00c, 32'h0);
      chk("unmapped error", {31'h0, errv}, 32'h1);
      $display("test registers done");
      xf(1'b1, DEE_OFS_CONTROL, 32'h08);
      rdc("power on", DEE_OFS_CONTROL, 32'h08);
      chk("power pin", {31'h0, nvmPowerOn}, 32'h1);
      for (int i = 0; i < 2; i++) begin
         xf(1'b1, DEE_OFS_ADDRESS, {25'h0, locs[i]});
         xf(1'b1, DEE_OFS_DATA, {24'h0, vals[i]});
         xf(1'b1, DEE_OFS_CONTROL, 32'h68);
         rdc("write busy", DEE_OFS_CONTROL, 32'h78);
         poll(DEE_BIT_WRITE);
         rdc("write done", DEE_OFS_CONTROL, 32'h28);
      end
      xf(1'b1, DEE_OFS_ADDRESS, 32'h7f);
      xf(1'b1, DEE_OFS_DATA, 32'h11);
      xf(1'b1, DEE_OFS_CONTROL, 32'h48);
      poll(DEE_BIT_WRITE);
      rdc("blocked write", DEE_OFS_CONTROL, 32'h08);
      $display("test write done");
      for (int i = 0; i < 2; i++) begin
         xf(1'b1, DEE_OFS_ADDRESS, {25'h0, locs[i]});
         xf(1'b1, DEE_OFS_DATA, 32'h00);
         xf(1'b1, DEE_OFS_CONTROL, 32'h88);
         poll(DEE_BIT_READ);
         rdc("read data", DEE_OFS_DATA, {24'h0, vals[i]});
      end
      $display("test read done");
      xf(1'b1, DEE_OFS_CONTROL, 32'h80);
      rdc("read pending", DEE_OFS_CONTROL, 32'h80);
      chk("power off", {31'h0, nvmPowerOn}, 32'h0);
      xf(1'b1, DEE_OFS_CONTROL, 32'h88);
      poll(DEE_BIT_READ);
      rdc("read after power", DEE_OFS_DATA, {24'h0, vals[1]});
      $display("test power done");
      results();
   end
endmodule
